// ---- shared/tmr_defines.vh ----
// Constants for the 8-bit timer/event counter: field positions, reset values.
// Assumes inclusion by plain Verilog-2005 design files.
`ifndef TMR_DEFINES_VH
`define TMR_DEFINES_VH

// ==========================================================================
// Control register fields
`define TMR_OP_HI_BIT 7
`define TMR_OP_LO_BIT 6
`define TMR_SRC_BIT 5
`define TMR_EN_BIT 4
`define TMR_EDGE_BIT 3
`define TMR_PSC_MSB 2
`define TMR_PSC_LSB 0
`define TMR_CTRL_RESET 8'h08
`define TMR_PRELOAD_RESET 8'h00
`define TMR_FULL_COUNT 8'hff

// ==========================================================================
// Operating modes
`define TMR_MODE_NONE 2'h0
`define TMR_MODE_EVENT 2'h1
`define TMR_MODE_TIMER 2'h2
`define TMR_MODE_PULSE 2'h3

`endif

// ---- rtl/tmr_prescaler.v ----
// Shared prescaler: picks the source tick and divides it by a power of two.
// Assumes source ticks are one-cycle enables already in the clk domain.
`timescale 1ns/1ps
`include "tmr_defines.vh"

module tmr_prescaler #(
  parameter STAGES = 7
) (
  input wire clk,
  input wire rst_b,
  input wire sys_tick,
  input wire lxt_tick,
  input wire tick_source_select,
  input wire pwm_any_enable,
  input wire [2:0] prescale_ratio,
  output wire shared_prescaler_clock,
  output reg prescaled_tick
);

  // ==========================================================================
  // Source select
  // PWM use pins the shared clock to the system clock
  assign shared_prescaler_clock = (tick_source_select && !pwm_any_enable) ?
                                  lxt_tick : sys_tick;

  // ==========================================================================
  // Divider
  // ones_below[n] is high while the low n divider bits are all ones
  reg [STAGES-1:0] div;
  wire [STAGES:0] ones_below;
  assign ones_below[0] = 1'b1;

  genvar g;
  generate
    for (g = 0; g < STAGES; g = g + 1) begin : g_ones
      assign ones_below[g+1] = ones_below[g] & div[g];
    end
  endgenerate

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div <= {STAGES{1'b0}};
      prescaled_tick <= 1'b0;
    end else begin
      if (shared_prescaler_clock)
        div <= div + {{(STAGES-1){1'b0}}, 1'b1};
      // Stage n-1 falls as the low n bits roll over: one tick per 2^n source ticks
      prescaled_tick <= shared_prescaler_clock && ones_below[prescale_ratio];
    end
  end

endmodule // tmr_prescaler

// ---- rtl/tmr_event_counter.v ----
// 8-bit count-up timer/event counter with preload and control registers.
// Assumes a processor data-memory port with one-cycle read/write strobes.
// What this block does
// - Count up to FFH, overflow, reload, continue
// - Disabled preload write copies into counter
// - Enabled preload write waits for next overflow
// - Timer read returns live count
// - Control bits 7:6 select operating mode
// - Bit 5 picks system or crystal clock
// - Any PWM enabled forces system clock
// - Bit 4 enables counting
// - Bit 3 selects event count edge
// - Pulse capture start/stop edges follow bit 3
// - Bits 2:0 divide by power of two
// - Timer/capture use prescaler; event uses pin
// - Each selected pin edge adds one
// - Preload undefined after power-on
// - Timer advances on prescaled falling edge
// - Capture arms on enable, starts on edge
// - Event counting continues asleep, unmasked overflow wakes
// - Interrupt gated by enable bit
`timescale 1ns/1ps
`include "tmr_defines.vh"

module tmr_event_counter (
  input wire clk,
  input wire rst_b,
  input wire preload_wr,
  input wire preload_rd,
  input wire ctrl_wr,
  input wire ctrl_rd,
  input wire [7:0] wr_data,
  output reg [7:0] rd_data,
  input wire sys_tick,
  input wire lxt_tick,
  input wire pwm_any_enable,
  input wire overflow_irq_enable,
  input wire ext_count_pin,
  output wire shared_prescaler_clock,
  output reg overflow_irq,
  output wire wake_request,
  output wire [7:0] timer_control_out
);

  // ==========================================================================
  // Registers
  reg [7:0] timer_control;
  reg [7:0] preload;
  reg [7:0] count;
  reg pin_s1;
  reg pin_s2;
  reg pin_prev;
  reg capturing;
  reg step;

  // Next-state values
  reg [7:0] next_timer_control;
  reg [7:0] next_preload;
  reg [7:0] next_count;
  reg next_capturing;
  reg next_overflow_irq;
  reg [7:0] next_rd_data;

  // Decoded fields and strobes
  wire prescaled_tick;
  wire [1:0] mode;
  wire count_enable;
  wire edge_select;
  wire tick_source_select;
  wire [2:0] prescale_ratio;
  wire mode_active;
  wire pin_rise;
  wire pin_fall;
  wire event_edge;
  wire cap_start;
  wire cap_stop;
  wire at_full;
  wire overflow;

  // ==========================================================================
  // Control fields
  assign mode = timer_control[`TMR_OP_HI_BIT:`TMR_OP_LO_BIT];
  assign tick_source_select = timer_control[`TMR_SRC_BIT];
  assign count_enable = timer_control[`TMR_EN_BIT];
  assign edge_select = timer_control[`TMR_EDGE_BIT];
  assign prescale_ratio = timer_control[`TMR_PSC_MSB:`TMR_PSC_LSB];
  assign mode_active = (mode != `TMR_MODE_NONE);
  assign timer_control_out = timer_control;

  // ==========================================================================
  // Shared prescaler
  // The PWM override sits in the prescaler: the shared clock is not ours alone
  tmr_prescaler #(
    .STAGES(7)
  ) u_psc (
    .clk(clk),
    .rst_b(rst_b),
    .sys_tick(sys_tick),
    .lxt_tick(lxt_tick),
    .tick_source_select(tick_source_select),
    .pwm_any_enable(pwm_any_enable),
    .prescale_ratio(prescale_ratio),
    .shared_prescaler_clock(shared_prescaler_clock),
    .prescaled_tick(prescaled_tick)
  );

  // ==========================================================================
  // Pin synchroniser
  // Two flops before any logic; only the second stage fans out
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end else begin
      pin_s1 <= ext_count_pin;
      pin_s2 <= pin_s1;
    end
  end

  // Edge history; reset low matches the idle pin, so no false edge
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin_s2;
    end
  end

  // ==========================================================================
  // Edge decode
  assign pin_rise = pin_s2 && !pin_prev;
  assign pin_fall = !pin_s2 && pin_prev;
  // Event edge: 0 rising, 1 falling
  assign event_edge = edge_select ? pin_fall : pin_rise;
  // Capture: 0 starts on fall, stops on rise; 1 the reverse
  assign cap_start = edge_select ? pin_rise : pin_fall;
  assign cap_stop = edge_select ? pin_fall : pin_rise;

  // ==========================================================================
  // Count step
  // Mode 00 never steps, even with the enable bit set
  always @* begin
    step = 1'b0;
    if (count_enable && mode_active) begin
      case (mode)
        `TMR_MODE_EVENT: begin
          // Pin path has no prescaler and no sleep gating
          step = event_edge;
        end
        `TMR_MODE_TIMER: begin
          step = prescaled_tick;
        end
        `TMR_MODE_PULSE: begin
          step = prescaled_tick && capturing;
        end
        default: begin
          step = 1'b0;
        end
      endcase
    end
  end

  assign at_full = (count == `TMR_FULL_COUNT);
  assign overflow = step && at_full;

  // ==========================================================================
  // Capture gate
  always @* begin
    next_capturing = capturing;
    if (!count_enable || mode != `TMR_MODE_PULSE) begin
      // Disarmed whenever stopped or out of capture mode
      next_capturing = 1'b0;
    end else if (!capturing && cap_start) begin
      next_capturing = 1'b1;
    end else if (capturing && cap_stop) begin
      next_capturing = 1'b0;
    end
  end

  // ==========================================================================
  // Register write decode
  always @* begin
    next_timer_control = timer_control;
    next_preload = preload;
    if (ctrl_wr) begin
      next_timer_control = wr_data;
    end
    if (preload_wr) begin
      next_preload = wr_data;
    end
  end

  // ==========================================================================
  // Next count
  // A write that meets an overflow reloads the new value, not the stale one
  always @* begin
    next_count = count;
    if (preload_wr && !count_enable) begin
      next_count = wr_data;
    end else if (overflow) begin
      if (preload_wr) begin
        next_count = wr_data;
      end else begin
        next_count = preload;
      end
    end else if (step) begin
      next_count = count + 8'h01;
    end
  end

  // ==========================================================================
  // Next interrupt request
  // One clock per overflow; it stays high while overflows come on back-to-back clocks (preload FFH, a step every clock)
  always @* begin
    next_overflow_irq = 1'b0;
    if (overflow && overflow_irq_enable) begin
      next_overflow_irq = 1'b1;
    end
  end

  // Wake follows the gated request; a masked overflow wakes nothing
  assign wake_request = overflow_irq;

  // ==========================================================================
  // Next read data
  // Idle read data is zero, so a stale value never looks like a fresh read
  always @* begin
    next_rd_data = 8'h00;
    if (preload_rd) begin
      next_rd_data = count;
    end else if (ctrl_rd) begin
      next_rd_data = timer_control;
    end
  end

  // ==========================================================================
  // Control register
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_control <= `TMR_CTRL_RESET;
    end else begin
      timer_control <= next_timer_control;
    end
  end

  // ==========================================================================
  // Preload register
  // No meaningful power-on value; zero only avoids X in sim
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      preload <= `TMR_PRELOAD_RESET;
    end else begin
      preload <= next_preload;
    end
  end

  // ==========================================================================
  // Counting register
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= `TMR_PRELOAD_RESET;
    end else begin
      count <= next_count;
    end
  end

  // ==========================================================================
  // Capture state
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      capturing <= 1'b0;
    end else begin
      capturing <= next_capturing;
    end
  end

  // ==========================================================================
  // Interrupt request
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= next_overflow_irq;
    end
  end

  // ==========================================================================
  // Read data
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule // tmr_event_counter

// ---- test/tmr_asserts.sv ----
// Port checker for the timer/event counter.
// Assumes it is bound onto tmr_event_counter.
`timescale 1ns/1ps
module tmr_asserts (
  input wire clk, input wire rst_b, input wire preload_wr, input wire preload_rd,
  input wire ctrl_wr, input wire ctrl_rd, input wire [7:0] wr_data, input wire [7:0] rd_data,
  input wire overflow_irq_enable, input wire overflow_irq, input wire wake_request,
  input wire [7:0] timer_control_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // Register port
  sequence quiet_pre_w;
    preload_wr && !timer_control_out[4] && !ctrl_wr;
  endsequence
  ctrl_store_a: assert property ($past(ctrl_wr) |-> timer_control_out == $past(wr_data))
    else $error("control store wrong");
  sequence gap_then_rd;
    !preload_wr && !ctrl_wr ##1 preload_rd;
  endsequence
  pre_copy_a: assert property (quiet_pre_w ##1 gap_then_rd |=> rd_data == $past(wr_data, 3))
    else $error("stopped preload not copied");
  rd_idle_a: assert property (!$past(preload_rd) && !$past(ctrl_rd) |-> rd_data == 8'h00)
    else $error("read data not idle");
  ctrl_read_a: assert property ($past(ctrl_rd) && !$past(ctrl_wr) |-> rd_data == $past(timer_control_out))
    else $error("control read wrong");
  // ==========================================================================
  // Overflow request
  wake_same_a: assert property (wake_request == overflow_irq)
    else $error("wake differs from irq");
  irq_gate_a: assert property (!overflow_irq_enable && !$past(overflow_irq_enable) |-> !overflow_irq)
    else $error("irq while masked");
  mode_none_a: assert property (timer_control_out[7:6] == 2'h0 && $past(timer_control_out[7:6]) == 2'h0 |-> !overflow_irq)
    else $error("irq in mode none");
  enable_off_a: assert property (!timer_control_out[4] && !$past(timer_control_out[4]) |-> !overflow_irq)
    else $error("irq while stopped");
  irq_pulse_a: assert property (overflow_irq && timer_control_out[7:6] == 2'h2 && timer_control_out[0] |=> !overflow_irq)
    else $error("irq wider than one cycle");
endmodule // tmr_asserts

// ---- test/tmr_pin_src.sv ----
// Model of the external pulse source on the count pin.
// Assumes the bench calls toggle_pin; the pin starts low.
`timescale 1ns/1ps
module tmr_pin_src (
  input wire clk,
  output reg ext_count_pin
);
  initial ext_count_pin = 1'b0;
  // ==========================================================================
  // Edges six cycles apart, well clear of the synchroniser delay
  task toggle_pin(input integer n);
    integer i;
    for (i = 0; i < n; i = i + 1) begin
      repeat (6) @(posedge clk);
      #1 ext_count_pin = !ext_count_pin;
    end
  endtask
endmodule // tmr_pin_src

// ---- test/tb_top.sv ----
// Self-checking bench for tmr_event_counter.
// Assumes the pin source model and the checker are compiled alongside.
`timescale 1ns/1ps
module tb_top;
  reg clk, rst_b, preload_wr, preload_rd, ctrl_wr, ctrl_rd, sys_tick, lxt_tick, pwm, irq_en;
  reg rd_pend = 1'b0;
  integer n_irq = 0;
  reg [7:0] wr_data;
  reg [31:0] seed;
  reg [15:0] exp_q [$];
  wire [7:0] rd_data, ctl;
  wire pin, irq;
  integer miscompares, n_tests, i, t, k;
  tmr_event_counter tmr_event_counter_inst (.clk(clk), .rst_b(rst_b), .preload_wr(preload_wr),
    .preload_rd(preload_rd), .ctrl_wr(ctrl_wr), .ctrl_rd(ctrl_rd), .wr_data(wr_data),
    .rd_data(rd_data), .sys_tick(sys_tick), .lxt_tick(lxt_tick), .pwm_any_enable(pwm),
    .overflow_irq_enable(irq_en), .ext_count_pin(pin), .shared_prescaler_clock(),
    .overflow_irq(irq), .wake_request(), .timer_control_out(ctl));
  tmr_pin_src tmr_pin_src_inst (.clk(clk), .ext_count_pin(pin));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end
  // ==========================================================================
  // Helpers
  function [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task chk(input string nm, input [15:0] seen, input [15:0] want);
    n_tests = n_tests + 1;
    if (seen !== want) begin
      miscompares = miscompares + 1;
      $display("ERROR %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task acc(input w, input c, input [7:0] d);
    @(posedge clk);
    #1 {ctrl_wr, preload_wr, ctrl_rd, preload_rd} = {w & c, w & !c, !w & c, !w & !c};
    wr_data = d;
    if (!w) exp_q.push_back({8'h00, d});
    @(posedge clk);
    #1 {ctrl_wr, preload_wr, ctrl_rd, preload_rd} = 4'h0;
  endtask
  // Cycles until the next irq pulse, bounded against a hang
  task wait_irq;
    t = 0;
    @(posedge clk);
    while (irq !== 1'b1 && t < 1200) begin
      t = t + 1;
      @(posedge clk);
    end
    if (t >= 1200) miscompares = miscompares + 1;
  endtask
  task period(input [15:0] p);
    repeat (3) wait_irq;
    chk("period", t + 1, p);
  endtask
  task quiet;
    k = n_irq;
    repeat (40) @(posedge clk);
    chk("no_irq", n_irq - k, 0);
  endtask
  always @(posedge clk) begin
    if (rd_pend) chk("rd_data", rd_data, exp_q.pop_front());
    rd_pend <= preload_rd | ctrl_rd;
    if (irq === 1'b1) n_irq = n_irq + 1;
  end
  task report_and_stop;
    if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000 miscompares = miscompares + 1;
    report_and_stop;
  end
  // ==========================================================================
  // Scenarios
  initial begin
    {rst_b, preload_wr, preload_rd, ctrl_wr, ctrl_rd, lxt_tick, pwm} = 7'h00;
    {sys_tick, irq_en, wr_data, seed} = {2'h3, 8'h00, 32'd87667};
    {miscompares, n_tests} = 0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    acc(0, 1, 8'h08);
    for (i = 0; i < 4; i = i + 1) begin
      seed = xs(seed);
      acc(1, 0, seed[7:0]);
      acc(0, 0, seed[7:0]);
    end
    acc(1, 0, 8'hfc);
    for (i = 0; i < 8; i = i + 1) begin
      acc(1, 1, 8'h90 | i);
      period(16'd4 << i);
    end
    acc(1, 0, 8'h10);
    acc(0, 0, 8'hfc);
    wait_irq;
    acc(0, 0, 8'h10);
    acc(1, 0, 8'hfc);
    acc(1, 1, 8'hb0);
    quiet;
    #1 lxt_tick = 1'b1;
    period(4);
    #1 {lxt_tick, pwm} = 2'h1;
    period(4);
    #1 {pwm, irq_en} = 2'h0;
    quiet;
    acc(1, 1, 8'h10);
    #1 irq_en = 1'b1;
    quiet;
    acc(1, 1, 8'h80);
    quiet;
    for (i = 0; i < 2; i = i + 1) begin
      acc(1, 1, 8'h40 | (i << 3));
      acc(1, 0, 8'hfc);
      acc(1, 1, 8'h50 | (i << 3));
      k = n_irq;
      tmr_pin_src_inst.toggle_pin(7);
      repeat (8) @(posedge clk);
      chk("ev_irq", n_irq - k, 1);
      acc(0, 0, 8'hfc);
    end
    acc(1, 1, 8'hc0);
    acc(1, 0, 8'h00);
    acc(1, 1, 8'hd0);
    tmr_pin_src_inst.toggle_pin(3);
    repeat (10) @(posedge clk);
    acc(0, 0, 8'h06);
    repeat (3) @(posedge clk);
    report_and_stop;
  end
endmodule // tb_top
bind tmr_event_counter tmr_asserts tmr_asserts_inst (.clk(clk), .rst_b(rst_b),
  .preload_wr(preload_wr), .preload_rd(preload_rd), .ctrl_wr(ctrl_wr), .ctrl_rd(ctrl_rd),
  .wr_data(wr_data), .rd_data(rd_data), .overflow_irq_enable(overflow_irq_enable),
  .overflow_irq(overflow_irq), .wake_request(wake_request),
  .timer_control_out(timer_control_out));
